// *** sol_channel.sv ***
`timescale 1ns/10ps
`default_nettype none
module sol_channel
    import sol_pkg::*;
(
    input  wire logic               clk,
    input  wire logic               sys_rst,
    input  wire logic               en_pin,
    input  wire logic               side_select_pin,
    input  wire logic               en_bit_set,
    input  wire logic               en_bit_clr,
    input  wire logic               sp_wr,
    input  wire logic [SP_W-1:0]    sp_wdata,
    input  wire logic [SR_W-1:0]    slew_wdata,
    input  wire logic               slew_wr,
    input  wire logic               az_done,
    input  wire logic [OFS_W-1:0]   az_offset,
    output logic                    hs_on,
    output logic                    ls_on,
    output logic                    en_bit,
    output logic [SP_W-1:0]         sp_rd,
    output logic                    side_lowside,
    output logic [SR_W-1:0]         slew_rd,
    output logic [SP_W-1:0]         eff_sp
);
    import sol_pkg::*;

    // ----------------------------------------------------------------
    // Registers
    // ----------------------------------------------------------------
    logic                 en_ff;
    logic [SP_W-1:0]      sp_ff;
    logic [SR_W-1:0]      slew_ff;
    logic                 side_ff;
    logic                 side_cap_ff;
    logic [OFS_W-1:0]     ofs_ff;
    logic [SP_W-1:0]      eff_ff;
    logic [PWM_W-1:0]     acc_ff;
    logic [3:0]           dead_ff;
    sw_state_type         st_ff;
    sw_state_type         after_dead_ff;
    logic                 hs_ff;
    logic                 ls_ff;

    // ----------------------------------------------------------------
    // Enable and target
    // ----------------------------------------------------------------
    wire              nxt_en    = en_pin & ((en_ff | en_bit_set) & ~en_bit_clr);
    wire              disabled  = ~en_pin | ~en_ff | (sp_ff == SP_RST);
    wire [SP_W:0]     sp_sum    = {1'b0, sp_ff} + {{(SP_W+1-OFS_W){1'b0}}, ofs_ff};
    // Saturate so a large offset never wraps the target to a small current
    wire [SP_W-1:0]   nxt_eff   = sp_sum[SP_W] ? {SP_W{1'b1}} : sp_sum[SP_W-1:0];
    // First-order duty modulator: carry out of accumulator marks drive phase
    wire [PWM_W:0]    acc_sum   = {1'b0, acc_ff} + {1'b0, eff_ff[SP_W-1 -: PWM_W]};
    wire              want_drv  = acc_sum[PWM_W] | (&eff_ff[SP_W-1 -: PWM_W]);
    wire              drv_on    = (st_ff == ST_DRIVE);
    wire              rec_on    = (st_ff == ST_RECIRC);
    wire              nxt_sr_ok = (slew_wdata <= SR_MAX);

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            en_ff       <= 1'b0;
            sp_ff       <= SP_RST;
            slew_ff     <= SR_RST;
            ofs_ff      <= OFS_RST;
            eff_ff      <= SP_RST;
            acc_ff      <= '0;
            side_cap_ff <= 1'b0;
            side_ff     <= 1'b0;
        end else begin
            en_ff   <= nxt_en;
            eff_ff  <= nxt_eff;
            acc_ff  <= acc_sum[PWM_W-1:0];
            // Strap caught after reset release, not under it
            if (!side_cap_ff) begin
                side_ff     <= side_select_pin;
                side_cap_ff <= 1'b1;
            end
            if (sp_wr) begin
                sp_ff <= sp_wdata;
            end
            if (slew_wr && nxt_sr_ok) begin
                slew_ff <= slew_wdata;
            end
            if (az_done) begin
                ofs_ff <= az_offset;
            end
        end
    end

    // ----------------------------------------------------------------
    // Switch sequencer
    // ----------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            st_ff         <= ST_OFF;
            after_dead_ff <= ST_OFF;
            dead_ff       <= '0;
        end else if (disabled) begin
            st_ff <= ST_OFF;
        end else begin
            case (st_ff)
                ST_OFF: begin
                    st_ff         <= ST_DEAD;
                    after_dead_ff <= ST_DRIVE;
                    dead_ff       <= 4'(DEAD_CYC);
                end
                ST_DRIVE: begin
                    if (!want_drv) begin
                        st_ff         <= ST_DEAD;
                        after_dead_ff <= ST_RECIRC;
                        dead_ff       <= 4'(DEAD_CYC);
                    end
                end
                ST_RECIRC: begin
                    if (want_drv) begin
                        st_ff         <= ST_DEAD;
                        after_dead_ff <= ST_DRIVE;
                        dead_ff       <= 4'(DEAD_CYC);
                    end
                end
                default: begin
                    if (dead_ff <= 4'h1) begin
                        st_ff <= after_dead_ff;
                    end
                    dead_ff <= dead_ff - 4'h1;
                end
            endcase
        end
    end

    // Lowside strap: low switch drives; highside strap: high switch drives
    wire nxt_hs = ~disabled & (side_ff ? rec_on : drv_on);
    wire nxt_ls = ~disabled & (side_ff ? drv_on : rec_on);

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            hs_ff <= 1'b0;
            ls_ff <= 1'b0;
        end else begin
            // States are exclusive, so at most one switch is ever on
            hs_ff <= nxt_hs & ~nxt_ls;
            ls_ff <= nxt_ls & ~nxt_hs;
        end
    end

    assign hs_on        = hs_ff;
    assign ls_on        = ls_ff;
    assign en_bit       = en_ff;
    assign sp_rd        = sp_ff;
    assign side_lowside = side_ff;
    assign slew_rd      = slew_ff;
    assign eff_sp       = eff_ff;

endmodule : sol_channel
`default_nettype wire

// *** sol_load.sv ***
`timescale 1ns/10ps
`default_nettype none
module sol_load
    import sol_pkg::*;
#(
    parameter logic [OFS_W-1:0] OFS = 6'h05
)
(
    input  wire logic [NUM_CH-1:0] hs_on,
    input  wire logic [NUM_CH-1:0] ls_on,
    output logic [OFS_W-1:0]       offset_meas
);
    // ------------------------------------------------------------
    // Sense path offset
    // ------------------------------------------------------------
    // Current still flowing skews the reading, as on a real coil
    assign offset_meas = OFS + OFS_W'(|(hs_on | ls_on));
endmodule : sol_load
`default_nettype wire

// *** sol_pkg.sv ***
// Function
// - Disabled channel turns both half-bridge switches off, output floats.
// - Channel disabled when enable pin low, enable bit low, or setpoint zero.
// - Lowside mode: lowside switch drives, highside switch recirculates.
// - Highside mode: highside switch drives, lowside switch recirculates.
// - Drive switch pulsed at regulating duty; recirculation on between drive pulses, after a dead time.
// - Drive and recirculation switches never commanded on together.
// - Low enable pin clears enable bit; rising pin leaves it cleared.
// - Sampled side selection is reported in the configuration readback.
// - Average current target comes from the channel setpoint register.
// - After power-up each channel measures its current path offset.
// - Measured offset adjusts the effective setpoint while regulating.
// - Offset correction never changes the setpoint register readback.
// - Each channel has its own independent control loop.
// - Two channels, each a two-switch half bridge; both share one offset_meas sense input.
// - Slew rate chosen by software from three settings.
package sol_pkg;

    // ----------------------------------------------------------------
    // Sizes and counts
    // ----------------------------------------------------------------
    localparam int          NUM_CH       = 2;
    localparam int          SP_W         = 11;
    localparam int          OFS_W        = 6;
    localparam int          SR_W         = 2;
    localparam int          DEAD_CYC     = 4;
    localparam int          AZ_CYC       = 64;
    localparam int          PWM_W        = 8;

    // ----------------------------------------------------------------
    // Reset values and encodings
    // ----------------------------------------------------------------
    localparam logic [SP_W-1:0]  SP_RST  = 11'h000;
    localparam logic [SR_W-1:0]  SR_RST  = 2'h0;
    localparam logic [SR_W-1:0]  SR_MAX  = 2'h2;
    localparam logic [OFS_W-1:0] OFS_RST = 6'h00;

    typedef enum logic [1:0] {
        ST_OFF,
        ST_DRIVE,
        ST_DEAD,
        ST_RECIRC
    } sw_state_type;

endpackage : sol_pkg

// *** sol_top.sv ***
`timescale 1ns/10ps
`default_nettype none
module sol_top
    import sol_pkg::*;
(
    input  wire logic                     clk,
    input  wire logic                     sys_rst,
    input  wire logic                     en_pin,
    input  wire logic                     side_select_pin_ch1,
    input  wire logic                     side_select_pin_ch2,
    input  wire logic [NUM_CH-1:0]        en_bit_set,
    input  wire logic [NUM_CH-1:0]        en_bit_clr,
    input  wire logic [NUM_CH-1:0]        sp_wr,
    input  wire logic [SP_W-1:0]          sp_wdata,
    input  wire logic [NUM_CH-1:0]        slew_wr,
    input  wire logic [SR_W-1:0]          slew_wdata,
    input  wire logic [NUM_CH-1:0]        az_start,
    input  wire logic [OFS_W-1:0]         offset_meas,
    output logic [NUM_CH-1:0]             hs_on,
    output logic [NUM_CH-1:0]             ls_on,
    output logic [NUM_CH-1:0]             en_bit,
    output logic [NUM_CH*SP_W-1:0]        sp_rd,
    output logic [NUM_CH-1:0]             side_lowside,
    output logic [NUM_CH*SR_W-1:0]        slew_rd,
    output logic [NUM_CH*SP_W-1:0]        eff_sp,
    output logic [NUM_CH*OFS_W-1:0]       offset_rd,
    output logic [NUM_CH-1:0]             az_busy
);
    import sol_pkg::*;

    // ----------------------------------------------------------------
    // Autozero sequencer, one per channel
    // ----------------------------------------------------------------
    // Offset is sampled at the end of the window; load current must be zero then
    logic [NUM_CH-1:0]        busy_ff;
    logic [NUM_CH-1:0]        done_ff;
    logic [NUM_CH*8-1:0]      azc_ff;
    logic [NUM_CH*OFS_W-1:0]  ofs_ff;
    wire  [NUM_CH-1:0]        side_pins = {side_select_pin_ch2, side_select_pin_ch1};

    genvar g;
    generate
        for (g = 0; g < NUM_CH; g++) begin : g_ch
            wire az_req = az_start[g] & ~en_bit[g] & ~busy_ff[g];
            wire az_end = busy_ff[g] & (azc_ff[g*8 +: 8] == 8'h01);

            always_ff @(posedge clk) begin
                if (sys_rst) begin
                    busy_ff[g]          <= 1'b1;
                    azc_ff[g*8 +: 8]    <= 8'(AZ_CYC);
                    done_ff[g]          <= 1'b0;
                    ofs_ff[g*OFS_W +: OFS_W] <= OFS_RST;
                end else begin
                    done_ff[g] <= az_end;
                    if (az_req) begin
                        busy_ff[g]       <= 1'b1;
                        azc_ff[g*8 +: 8] <= 8'(AZ_CYC);
                    end else if (az_end) begin
                        busy_ff[g] <= 1'b0;
                        ofs_ff[g*OFS_W +: OFS_W] <= offset_meas;
                    end else if (busy_ff[g]) begin
                        azc_ff[g*8 +: 8] <= azc_ff[g*8 +: 8] - 8'h01;
                    end
                end
            end

            sol_channel u_ch (
                .clk             (clk),
                .sys_rst         (sys_rst),
                .en_pin          (en_pin),
                .side_select_pin (side_pins[g]),
                .en_bit_set      (en_bit_set[g]),
                .en_bit_clr      (en_bit_clr[g]),
                .sp_wr           (sp_wr[g]),
                .sp_wdata        (sp_wdata),
                .slew_wdata      (slew_wdata),
                .slew_wr         (slew_wr[g]),
                .az_done         (done_ff[g]),
                .az_offset       (ofs_ff[g*OFS_W +: OFS_W]),
                .hs_on           (hs_on[g]),
                .ls_on           (ls_on[g]),
                .en_bit          (en_bit[g]),
                .sp_rd           (sp_rd[g*SP_W +: SP_W]),
                .side_lowside    (side_lowside[g]),
                .slew_rd         (slew_rd[g*SR_W +: SR_W]),
                .eff_sp          (eff_sp[g*SP_W +: SP_W])
            );
        end
    endgenerate

    assign offset_rd = ofs_ff;
    assign az_busy   = busy_ff;

endmodule : sol_top
`default_nettype wire

// *** sol_top_asserts.sv ***
`timescale 1ns/10ps
`default_nettype none
module sol_top_asserts
    import sol_pkg::*;
(
    input wire logic                 clk,
    input wire logic                 sys_rst,
    input wire logic                 en_pin,
    input wire logic [NUM_CH-1:0]    en_bit_set,
    input wire logic [NUM_CH-1:0]    sp_wr,
    input wire logic [SP_W-1:0]      sp_wdata,
    input wire logic [NUM_CH-1:0]    slew_wr,
    input wire logic [SR_W-1:0]      slew_wdata,
    input wire logic [NUM_CH-1:0]    hs_on,
    input wire logic [NUM_CH-1:0]    ls_on,
    input wire logic [NUM_CH-1:0]    en_bit,
    input wire logic [NUM_CH*SP_W-1:0] sp_rd,
    input wire logic [NUM_CH-1:0]    side_lowside,
    input wire logic [NUM_CH*SR_W-1:0] slew_rd
);
    // ------------------------------------------------------------
    // Switch and enable checks
    // ------------------------------------------------------------
    default clocking @(posedge clk); endclocking
    default disable iff (sys_rst);
    wire [1:0] dis = ~en_bit | {~|sp_rd[21:11], ~|sp_rd[10:0]} | {2{~en_pin}};
    wire       drv = side_lowside[0] ? ls_on[0] : hs_on[0];
    wire       rec = side_lowside[0] ? hs_on[0] : ls_on[0];
    sequence s_idle; !(hs_on[0] | ls_on[0]) [*8]; endsequence
    sequence s_start; hs_on[0] | ls_on[0]; endsequence
    property p_excl; (hs_on & ls_on) == 2'h0; endproperty
    property p_pin_low; !en_pin |=> en_bit == 2'h0; endproperty
    property p_pin_rise; $rose(en_pin) && en_bit_set == 2'h0 |=> en_bit == 2'h0; endproperty
    property p_off0; dis[0] [*3] |-> !(hs_on[0] | ls_on[0]); endproperty
    property p_off1; dis[1] [*3] |-> !(hs_on[1] | ls_on[1]); endproperty
    property p_first; s_idle ##1 s_start |-> ls_on[0] == side_lowside[0]; endproperty
    property p_freewheel; $fell(drv) |-> ##[1:12] (rec || dis[0]); endproperty
    property p_bbm; $fell(hs_on[0]) || $fell(ls_on[0]) |-> !(hs_on[0] | ls_on[0]) [*2]; endproperty
    property p_sp_rb; sp_wr[0] |=> sp_rd[10:0] == $past(sp_wdata); endproperty
    property p_slew;
        slew_wr[0] && slew_wdata != 2'h3 |=> slew_rd[1:0] == $past(slew_wdata);
    endproperty
    a_excl: assert property (p_excl) else $error("both switches on");
    a_pin_low: assert property (p_pin_low) else $error("enable bit kept");
    a_pin_rise: assert property (p_pin_rise) else $error("bit set by pin");
    a_off0: assert property (p_off0) else $error("ch1 not off");
    a_off1: assert property (p_off1) else $error("ch2 not off");
    a_first: assert property (p_first) else $error("wrong drive switch");
    a_freewheel: assert property (p_freewheel) else $error("no freewheel");
    a_bbm: assert property (p_bbm) else $error("no dead time");
    a_sp_rb: assert property (p_sp_rb) else $error("setpoint readback");
    a_slew: assert property (p_slew) else $error("slew readback");
endmodule : sol_top_asserts
`default_nettype wire

// *** sol_top_bench.sv ***
`timescale 1ns/10ps
`default_nettype none
module sol_top_bench;
    import sol_pkg::*;
    // ------------------------------------------------------------
    // Stimulus, model and checks
    // ------------------------------------------------------------
    localparam logic [OFS_W-1:0] OFS = 6'h05;
    logic clk = 1'b0, sys_rst = 1'b1, en_pin = 1'b0;
    logic [1:0] set = 2'h0, clr = 2'h0, spw = 2'h0, slw = 2'h0, azs = 2'h0;
    logic [SP_W-1:0] spd = 11'h000;
    logic [SR_W-1:0] sld = 2'h0;
    wire [OFS_W-1:0] ofs;
    wire [1:0] hs, ls, enb, sll, azb;
    wire [21:0] sprd, eff;
    wire [3:0] slrd;
    wire [11:0] ofrd;
    int miscompares = 0, tests_run = 0, c [4];
    logic [3:0] rows [4] = '{4'h0, 4'h5, 4'ha, 4'he}; // Write value, then expected
    always #5 clk = ~clk;
    sol_top sol_top_i (.clk(clk), .sys_rst(sys_rst), .en_pin(en_pin),
        .side_select_pin_ch1(1'b1), .side_select_pin_ch2(1'b0),
        .en_bit_set(set), .en_bit_clr(clr), .sp_wr(spw), .sp_wdata(spd), .slew_wr(slw),
        .slew_wdata(sld), .az_start(azs), .offset_meas(ofs), .hs_on(hs), .ls_on(ls),
        .en_bit(enb), .sp_rd(sprd), .side_lowside(sll), .slew_rd(slrd), .eff_sp(eff),
        .offset_rd(ofrd), .az_busy(azb));
    sol_load #(.OFS(OFS)) sol_load_i (.hs_on(hs), .ls_on(ls), .offset_meas(ofs));
    task automatic tick(input int k = 1);
        repeat (k) @(posedge clk);
        #1;
    endtask : tick
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            miscompares++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic test_done();
        $display("compares=%0d mismatches=%0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : test_done
    task automatic wait_az();
        for (int k = 0; azb !== 2'h0; k++) begin
            if (k == 200) begin
                miscompares++;
                test_done();
            end
            tick();
        end
    endtask : wait_az
    // Lowside ch1: drive ls, recirc hs; highside ch2: drive hs, recirc ls
    task automatic act(input int k);
        c = '{default: 0};
        repeat (k) begin
            tick();
            c[0] += ls[0];
            c[1] += hs[0];
            c[2] += hs[1];
            c[3] += ls[1];
        end
    endtask : act
    initial begin
        tick(4);
        chk({hs, ls, enb, azb}, 8'h03);
        sys_rst = 1'b0;
        tick(2);
        chk(sll, 2'h1);
        wait_az();
        chk(ofrd, {OFS, OFS});
        // Strobe held up across rows so it is never lowered and raised in one step
        slw = 2'h1;
        foreach (rows[i]) begin
            sld = rows[i][3:2];
            tick();
            chk(slrd[1:0], rows[i][1:0]);
        end
        slw = 2'h0;
        chk(slrd, 4'h2);
        set = 2'h3;
        tick();
        set = 2'h0;
        tick();
        chk(enb, 2'h0);
        en_pin = 1'b1;
        spd = 11'h100;
        spw = 2'h3;
        tick();
        spw = 2'h0;
        chk(sprd, {2{11'h100}});
        tick();
        chk(eff, {2{11'h105}});
        chk(hs | ls, 2'h0);
        set = 2'h3;
        tick();
        set = 2'h0;
        chk(enb, 2'h3);
        act(400);
        chk({c[0] != 0, c[1] != 0, c[2] != 0, c[3] != 0}, 4'hf);
        en_pin = 1'b0;
        tick();
        chk(enb, 2'h0);
        tick();
        chk(hs | ls, 2'h0);
        en_pin = 1'b1;
        tick(3);
        chk(enb, 2'h0);
        spd = 11'h000;
        spw = 2'h1;
        set = 2'h3;
        tick();
        {spw, set} = 4'h0;
        act(200);
        chk(c[0], 32'h0);
        chk(c[1], 32'h0);
        chk({c[2] != 0, c[3] != 0}, 2'h3);
        azs = 2'h2;
        tick();
        azs = 2'h0;
        chk(azb, 2'h0);
        clr = 2'h2;
        tick();
        clr = 2'h0;
        tick(8);
        azs = 2'h2;
        tick();
        azs = 2'h0;
        chk(azb, 2'h2);
        wait_az();
        chk(ofrd, {OFS, OFS});
        chk(sprd[21:11], 11'h100);
        test_done();
    end
endmodule : sol_top_bench
bind sol_top sol_top_asserts sol_top_asserts_i (.clk(clk), .sys_rst(sys_rst),
    .en_pin(en_pin), .en_bit_set(en_bit_set), .sp_wr(sp_wr), .sp_wdata(sp_wdata),
    .slew_wr(slew_wr), .slew_wdata(slew_wdata), .hs_on(hs_on), .ls_on(ls_on),
    .en_bit(en_bit), .sp_rd(sp_rd), .side_lowside(side_lowside), .slew_rd(slew_rd));
`default_nettype wire
